// *** rtl/motor_cfg_pkg.sv ***
package motor_cfg_pkg;

   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_FAULT_SETUP_TWO = 8'h92;
   localparam logic [7:0] OFS_PIN_SETUP = 8'ha4;
   localparam logic [7:0] OFS_DEVICE_ONE = 8'ha6;
   localparam logic [7:0] OFS_DEVICE_TWO = 8'ha8;
   localparam logic [7:0] OFS_PERIPH_ONE = 8'haa;
   localparam logic [7:0] OFS_GATE_ONE = 8'hac;
   localparam logic [7:0] OFS_GATE_TWO = 8'hae;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [31:0] RST_FAULT_SETUP_TWO = 32'h0000_0000;
   localparam logic [31:0] RST_PIN_SETUP = 32'h0000_0000;
   localparam logic [31:0] RST_DEVICE_ONE = 32'h0000_0000;
   localparam logic [31:0] RST_DEVICE_TWO = 32'h0000_0000;
   localparam logic [31:0] RST_PERIPH_ONE = 32'h4000_0000;
   localparam logic [31:0] RST_GATE_ONE = 32'h1022_8100;
   localparam logic [31:0] RST_GATE_TWO = 32'h0120_0000;

   // -----------------------------------------------------------------
   // field positions, fault setup two
   // -----------------------------------------------------------------
   localparam int FLOOR_LSB = 8;
   localparam int UV_RECOVERY_BIT = 7;
   localparam int CEILING_LSB = 4;
   localparam int OV_RECOVERY_BIT = 3;
   localparam int RETRY_LSB = 0;

   // -----------------------------------------------------------------
   // field positions, hardware pin setup
   // -----------------------------------------------------------------
   localparam int FILTER_OFF_BIT = 27;
   localparam int STOP_BEHAVIOUR_LSB = 9;
   localparam int FAULT_BEHAVIOUR_LSB = 7;
   localparam int ALARM_EN_BIT = 6;
   localparam int BRAKE_MODE_BIT = 5;
   localparam int ANGLE_SEL_BIT = 4;
   localparam int BRAKE_OVERRIDE_LSB = 2;
   localparam int SPEED_MODE_LSB = 0;

   // filter time constant as a shift
   localparam int FILTER_SHIFT = 3;

   typedef enum logic [1:0] {
      SPEED_ANALOG = 2'h0,
      SPEED_PWM = 2'h1,
      SPEED_FREQ = 2'h3
   } speed_mode_t;

   // supply floor in units of 0.1 V, code 0 unused
   function automatic logic [15:0] floor_dv(input logic [2:0] code);
      case (code)
         3'h1: floor_dv = 16'h002d;
         3'h2: floor_dv = 16'h0032;
         3'h3: floor_dv = 16'h0037;
         3'h4: floor_dv = 16'h003c;
         3'h5: floor_dv = 16'h004b;
         3'h6: floor_dv = 16'h0064;
         3'h7: floor_dv = 16'h007d;
         default: floor_dv = 16'h0000;
      endcase
   endfunction : floor_dv

   // supply ceiling in units of 0.1 V, code 0 unused
   function automatic logic [15:0] ceiling_dv(input logic [2:0] code);
      case (code)
         3'h1: ceiling_dv = 16'h00c8;
         3'h2: ceiling_dv = 16'h00e1;
         3'h3: ceiling_dv = 16'h00fa;
         3'h4: ceiling_dv = 16'h0113;
         3'h5: ceiling_dv = 16'h012c;
         3'h6: ceiling_dv = 16'h0145;
         3'h7: ceiling_dv = 16'h015e;
         default: ceiling_dv = 16'hffff;
      endcase
   endfunction : ceiling_dv

   // retry attempts, code 0 unused
   function automatic logic [4:0] retry_max(input logic [2:0] code);
      case (code)
         3'h1: retry_max = 5'h02;
         3'h2: retry_max = 5'h03;
         3'h3: retry_max = 5'h05;
         3'h4: retry_max = 5'h07;
         3'h5: retry_max = 5'h0a;
         3'h6: retry_max = 5'h0f;
         3'h7: retry_max = 5'h14;
         default: retry_max = 5'h00;
      endcase
   endfunction : retry_max

endpackage : motor_cfg_pkg

// *** rtl/supply_fault_latch.sv ***
`timescale 1ns/1ps
`default_nettype none

module supply_fault_latch
   import motor_cfg_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic out_of_bounds_i,
   input wire logic auto_recover_i,
   input wire logic clear_i,
   output logic fault_o,
   output logic recovered_o
);

   // -----------------------------------------------------------------
   // fault flag, set wins over every clear
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         fault_o <= 1'b0;
      end else if (out_of_bounds_i) begin
         fault_o <= 1'b1;
      end else if (auto_recover_i || clear_i) begin
         fault_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         recovered_o <= 1'b0;
      end else begin
         recovered_o <= fault_o && !out_of_bounds_i && auto_recover_i;
      end
   end

endmodule : supply_fault_latch

`default_nettype wire

// *** rtl/motor_hw_fault_config_bank.sv ***
`timescale 1ns/1ps
`default_nettype none

module motor_hw_fault_config_bank
   import motor_cfg_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_write_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_read_i,
   output logic [31:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire logic [15:0] supply_dv_i,
   input wire logic fault_clear_i,
   input wire logic other_fault_i,
   input wire logic motor_stopped_i,
   input wire logic commutation_feedback_i,
   input wire logic coasting_feedback_enable_i,
   input wire logic [15:0] backemf_level_i,
   input wire logic [15:0] feedback_backemf_threshold_i,
   input wire logic brake_pin_i,
   output logic [15:0] bus_volt_o,
   output logic undervoltage_fault_o,
   output logic overvoltage_fault_o,
   output logic speed_feedback_out_o,
   output logic alarm_o,
   output logic lowside_brake_o,
   output logic align_brake_o,
   output logic use_set_angle_o,
   output logic [1:0] speed_input_mode_o
);

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   // -----------------------------------------------------------------
   // register file
   // -----------------------------------------------------------------
   logic [31:0] fault_setup_two;
   logic [31:0] hardware_pin_setup;
   logic [31:0] device_setup_one;
   logic [31:0] device_setup_two;
   logic [31:0] peripheral_setup_one;
   logic [31:0] gate_driver_setup_one;
   logic [31:0] gate_driver_setup_two;
   logic [31:0] next_rdata;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         fault_setup_two <= RST_FAULT_SETUP_TWO;
         hardware_pin_setup <= RST_PIN_SETUP;
         device_setup_one <= RST_DEVICE_ONE;
         device_setup_two <= RST_DEVICE_TWO;
         peripheral_setup_one <= RST_PERIPH_ONE;
         gate_driver_setup_one <= RST_GATE_ONE;
         gate_driver_setup_two <= RST_GATE_TWO;
      end else if (reg_write_i) begin
         case (reg_addr_i)
            OFS_FAULT_SETUP_TWO: fault_setup_two <= reg_wdata_i;
            OFS_PIN_SETUP: hardware_pin_setup <= reg_wdata_i;
            OFS_DEVICE_ONE: device_setup_one <= reg_wdata_i;
            OFS_DEVICE_TWO: device_setup_two <= reg_wdata_i;
            OFS_PERIPH_ONE: peripheral_setup_one <= reg_wdata_i;
            OFS_GATE_ONE: gate_driver_setup_one <= reg_wdata_i;
            OFS_GATE_TWO: gate_driver_setup_two <= reg_wdata_i;
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // read port
   // -----------------------------------------------------------------
   always_comb begin
      case (reg_addr_i)
         OFS_FAULT_SETUP_TWO: next_rdata = fault_setup_two;
         OFS_PIN_SETUP: next_rdata = hardware_pin_setup;
         OFS_DEVICE_ONE: next_rdata = device_setup_one;
         OFS_DEVICE_TWO: next_rdata = device_setup_two;
         OFS_PERIPH_ONE: next_rdata = peripheral_setup_one;
         OFS_GATE_ONE: next_rdata = gate_driver_setup_one;
         OFS_GATE_TWO: next_rdata = gate_driver_setup_two;
         default: next_rdata = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         reg_rdata_o <= 32'h0000_0000;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_read_i;
         if (reg_read_i) begin
            reg_rdata_o <= next_rdata;
         end
      end
   end

   // -----------------------------------------------------------------
   // field decode
   // -----------------------------------------------------------------
   logic [2:0] supply_floor_select;
   logic [2:0] supply_ceiling_select;
   logic [2:0] retry_limit_code;
   logic undervoltage_recovery;
   logic overvoltage_recovery;
   logic bus_volt_filter_off;
   logic [1:0] speed_feedback_stop_behaviour;
   logic [1:0] speed_feedback_fault_behaviour;
   logic [1:0] brake_override;
   assign supply_floor_select = fault_setup_two[FLOOR_LSB +: 3];
   assign undervoltage_recovery = fault_setup_two[UV_RECOVERY_BIT];
   assign supply_ceiling_select = fault_setup_two[CEILING_LSB +: 3];
   assign overvoltage_recovery = fault_setup_two[OV_RECOVERY_BIT];
   assign retry_limit_code = fault_setup_two[RETRY_LSB +: 3];
   assign bus_volt_filter_off = hardware_pin_setup[FILTER_OFF_BIT];
   assign speed_feedback_stop_behaviour =
      hardware_pin_setup[STOP_BEHAVIOUR_LSB +: 2];
   assign speed_feedback_fault_behaviour =
      hardware_pin_setup[FAULT_BEHAVIOUR_LSB +: 2];
   assign brake_override = hardware_pin_setup[BRAKE_OVERRIDE_LSB +: 2];

   // -----------------------------------------------------------------
   // bus voltage filter
   // -----------------------------------------------------------------
   logic [18:0] filter_acc;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         filter_acc <= 19'h0_0000;
      end else begin
         filter_acc <= filter_acc - (filter_acc >> FILTER_SHIFT)
                       + {3'h0, supply_dv_i};
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         bus_volt_o <= 16'h0000;
      end else if (bus_volt_filter_off) begin
         bus_volt_o <= supply_dv_i;
      end else begin
         bus_volt_o <= filter_acc[FILTER_SHIFT +: 16];
      end
   end

   // -----------------------------------------------------------------
   // supply faults and retry limit
   // -----------------------------------------------------------------
   logic under_oob;
   logic over_oob;
   logic retry_allowed;
   logic uv_recovered;
   logic ov_recovered;
   logic [4:0] retry_count;
   assign under_oob = (supply_floor_select != 3'h0) &&
                      (bus_volt_o < floor_dv(supply_floor_select));
   assign over_oob = (supply_ceiling_select != 3'h0) &&
                     (bus_volt_o > ceiling_dv(supply_ceiling_select));
   assign retry_allowed = (retry_limit_code == 3'h0) ||
                          (retry_count < retry_max(retry_limit_code));
   supply_fault_latch under_latch (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .out_of_bounds_i(under_oob),
      .auto_recover_i(undervoltage_recovery && retry_allowed),
      .clear_i(fault_clear_i),
      .fault_o(undervoltage_fault_o),
      .recovered_o(uv_recovered)
   );
   supply_fault_latch over_latch (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .out_of_bounds_i(over_oob),
      .auto_recover_i(overvoltage_recovery && retry_allowed),
      .clear_i(fault_clear_i),
      .fault_o(overvoltage_fault_o),
      .recovered_o(ov_recovered)
   );
   always_ff @(posedge clk_i) begin
      if (reset_i || fault_clear_i) begin
         retry_count <= 5'h00;
      end else if ((uv_recovered || ov_recovered) &&
                   retry_count != 5'h1f) begin
         retry_count <= retry_count + 5'h01;
      end
   end

   // -----------------------------------------------------------------
   // speed feedback and alarm pins
   // -----------------------------------------------------------------
   logic any_fault;
   logic last_driven;
   logic next_feedback;
   assign any_fault = undervoltage_fault_o || overvoltage_fault_o ||
                      other_fault_i;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         last_driven <= 1'b0;
      end else if (!any_fault && !motor_stopped_i) begin
         last_driven <= commutation_feedback_i;
      end
   end
   always_comb begin
      next_feedback = commutation_feedback_i;
      if (any_fault) begin
         case (speed_feedback_fault_behaviour)
            2'h0: next_feedback = last_driven;
            2'h1: next_feedback = 1'b1;
            2'h2: next_feedback = 1'b0;
            default: next_feedback = coasting_feedback_enable_i &&
               (backemf_level_i >= feedback_backemf_threshold_i) ?
               commutation_feedback_i : speed_feedback_out_o;
         endcase
      end else if (motor_stopped_i) begin
         case (speed_feedback_stop_behaviour)
            2'h0: next_feedback = commutation_feedback_i;
            2'h2: next_feedback = 1'b0;
            default: next_feedback = 1'b1;
         endcase
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         speed_feedback_out_o <= 1'b0;
         alarm_o <= 1'b0;
      end else begin
         speed_feedback_out_o <= next_feedback;
         alarm_o <= hardware_pin_setup[ALARM_EN_BIT] && any_fault;
      end
   end

   // -----------------------------------------------------------------
   // brake pin and speed mode
   // -----------------------------------------------------------------
   logic brake_meta;
   logic brake_sync;
   logic brake_request;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         brake_meta <= 1'b0;
         brake_sync <= 1'b0;
      end else begin
         brake_meta <= brake_pin_i;
         brake_sync <= brake_meta;
      end
   end
   always_comb begin
      case (brake_override)
         2'h1: brake_request = 1'b1;
         2'h2: brake_request = 1'b0;
         default: brake_request = brake_sync;
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         lowside_brake_o <= 1'b0;
         align_brake_o <= 1'b0;
         use_set_angle_o <= 1'b0;
         speed_input_mode_o <= SPEED_ANALOG;
      end else begin
         lowside_brake_o <= brake_request &&
                            !hardware_pin_setup[BRAKE_MODE_BIT];
         align_brake_o <= brake_request &&
                          hardware_pin_setup[BRAKE_MODE_BIT];
         use_set_angle_o <= brake_request &&
                            hardware_pin_setup[BRAKE_MODE_BIT] &&
                            hardware_pin_setup[ANGLE_SEL_BIT];
         case (hardware_pin_setup[SPEED_MODE_LSB +: 2])
            2'h1: speed_input_mode_o <= SPEED_PWM;
            2'h3: speed_input_mode_o <= SPEED_FREQ;
            default: speed_input_mode_o <= SPEED_ANALOG;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   a_uv_latched: assert property (undervoltage_fault_o &&
      !undervoltage_recovery && !fault_clear_i |=> undervoltage_fault_o)
      else $error("undervoltage fault dropped while latched");
   a_ov_sets: assert property (over_oob |=> overvoltage_fault_o)
      else $error("overvoltage not flagged");
   a_ov_autoclear: assert property (overvoltage_fault_o &&
      overvoltage_recovery && retry_allowed && !over_oob
      |=> !overvoltage_fault_o)
      else $error("overvoltage did not auto clear");
   a_retry_cap: assert property (undervoltage_fault_o &&
      (retry_limit_code != 3'h0) && !fault_clear_i &&
      (retry_count >= retry_max(retry_limit_code)) |=> undervoltage_fault_o)
      else $error("retry limit exceeded");
   a_filter_bypass: assert property (bus_volt_filter_off
      |=> bus_volt_o == $past(supply_dv_i))
      else $error("filter not bypassed");
   a_stop_low: assert property (motor_stopped_i && !any_fault &&
      speed_feedback_stop_behaviour == 2'h2 ##1 1'b1
      |-> !speed_feedback_out_o)
      else $error("stopped feedback not low");
   a_fault_high: assert property (any_fault &&
      speed_feedback_fault_behaviour == 2'h1 |=> speed_feedback_out_o)
      else $error("fault feedback not high");
   a_alarm_gate: assert property (!hardware_pin_setup[ALARM_EN_BIT]
      |=> !alarm_o)
      else $error("alarm driven while disabled");
   a_brake_off: assert property (brake_override == 2'h2
      |=> !lowside_brake_o && !align_brake_o)
      else $error("brake active under forced off");
   a_brake_kind: assert property (brake_override == 2'h1 &&
      !hardware_pin_setup[BRAKE_MODE_BIT] |=> lowside_brake_o)
      else $error("low side brake missing");
   a_gate_reset: assert property (@(posedge clk_i) disable iff (1'b0)
      reset_i |=> gate_driver_setup_one == RST_GATE_ONE)
      else $error("gate driver reset value wrong");
   c_uv_recover: cover property (uv_recovered);
   c_ov_latch: cover property (overvoltage_fault_o && !overvoltage_recovery);
   c_align: cover property (align_brake_o && use_set_angle_o);
   c_fault_feedback: cover property (any_fault &&
      speed_feedback_fault_behaviour == 2'h3);

endmodule : motor_hw_fault_config_bank

`default_nettype wire

// *** verification/motor_hw_fault_config_bank_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module motor_hw_fault_config_bank_bench
   import motor_cfg_pkg::*;
;
   // ---------------------------------------------------------------
   // stimulus and observed signals
   // ---------------------------------------------------------------
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [15:0] supply = 16'h0096;
   logic clr = 1'b0;
   logic ofault = 1'b0;
   logic stopped = 1'b0;
   logic comm = 1'b0;
   logic coast = 1'b0;
   logic [15:0] bemf = 16'h0;
   logic [15:0] bthr = 16'h0;
   logic brake = 1'b0;
   logic [31:0] rdata;
   logic rvalid, uv, ov, fb, alarm, lsb, alb, angle;
   logic [15:0] bus_volt;
   logic [1:0] smode;
   logic [15:0] lfsr = 16'd47820;
   int mismatches = 0;
   int total_checks = 0;
   logic [7:0] ofs [7] = '{OFS_FAULT_SETUP_TWO, OFS_PIN_SETUP, OFS_DEVICE_ONE,
      OFS_DEVICE_TWO, OFS_PERIPH_ONE, OFS_GATE_ONE, OFS_GATE_TWO};
   logic [31:0] rst [7] = '{RST_FAULT_SETUP_TWO, RST_PIN_SETUP, RST_DEVICE_ONE,
      RST_DEVICE_TWO, RST_PERIPH_ONE, RST_GATE_ONE, RST_GATE_TWO};
   int fl [8] = '{0, 45, 50, 55, 60, 75, 100, 125};
   int ce [8] = '{0, 200, 225, 250, 275, 300, 325, 350};
   int rt [8] = '{0, 2, 3, 5, 7, 10, 15, 20};

   motor_hw_fault_config_bank i_motor_hw_fault_config_bank (
      .clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(addr),
      .reg_write_i(wr), .reg_wdata_i(wdata), .reg_read_i(rd),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .supply_dv_i(supply),
      .fault_clear_i(clr), .other_fault_i(ofault),
      .motor_stopped_i(stopped), .commutation_feedback_i(comm),
      .coasting_feedback_enable_i(coast), .backemf_level_i(bemf),
      .feedback_backemf_threshold_i(bthr), .brake_pin_i(brake),
      .bus_volt_o(bus_volt), .undervoltage_fault_o(uv),
      .overvoltage_fault_o(ov), .speed_feedback_out_o(fb),
      .alarm_o(alarm), .lowside_brake_o(lsb), .align_brake_o(alb),
      .use_set_angle_o(angle), .speed_input_mode_o(smode)
   );

   always #10 clk_i = ~clk_i;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function logic [31:0] rand32();
      repeat (32) begin
         lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      end
      return {lfsr, lfsr ^ 16'h5a5a};
   endfunction : rand32

   function logic exp_stop(input int code, input logic live);
      return code == 0 ? live : code != 2;
   endfunction : exp_stop

   function logic exp_fault(input int code, input logic held,
                            input logic live);
      return code == 0 ? held : code == 3 ? live : code == 1;
   endfunction : exp_fault

   function logic exp_brake(input int code, input logic pin);
      return code == 1 ? 1'b1 : code == 2 ? 1'b0 : pin;
   endfunction : exp_brake

   task end_sim();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim

   task check(input string what, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : check

   task step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : step

   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask : wr_reg

   task rd_reg(input logic [7:0] a, output logic [31:0] d);
      int n;
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1;
      n = 0;
      while (rvalid !== 1'b1 && n < 4) begin
         step(1);
         n++;
      end
      if (rvalid !== 1'b1) begin
         mismatches++;
         $display("Error read valid expected 1 seen %b", rvalid);
         end_sim();
      end else begin
         d = rdata;
      end
   endtask : rd_reg

   task sup(input int v);
      @(posedge clk_i);
      supply <= 16'(v);
      step(4);
   endtask : sup

   task clear();
      @(posedge clk_i);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      step(3);
   endtask : clear

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] v;
      logic [31:0] e;
      logic k;
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         rd_reg(ofs[i], v);
         check("reset value", rst[i], v);
      end
      for (int i = 0; i < 7; i++) begin
         e = rand32();
         wr_reg(ofs[i], e);
         rd_reg(ofs[i], v);
         check("register data", e, v);
      end
      rd_reg(8'ha5, v);
      check("unmapped read", 32'h0, v);
      wr_reg(OFS_PIN_SETUP, 32'h0800_0000);
      for (int c = 0; c < 8; c++) begin
         wr_reg(OFS_FAULT_SETUP_TWO, 32'((c << 8) | 8'h80));
         clear();
         sup(c == 0 ? 0 : fl[c] - 1);
         check("uv below floor", c != 0, uv);
         sup(fl[c]);
         check("uv at floor", 0, uv);
         wr_reg(OFS_FAULT_SETUP_TWO, 32'((c << 4) | 8'h08));
         sup(c == 0 ? 16'hffff : ce[c] + 1);
         check("ov above ceiling", c != 0, ov);
         sup(ce[c]);
         check("ov at ceiling", 0, ov);
      end
      wr_reg(OFS_FAULT_SETUP_TWO, 32'h0000_0110);
      sup(44);
      sup(150);
      check("uv latched", 1, uv);
      clear();
      check("uv cleared", 0, uv);
      sup(201);
      sup(150);
      check("ov latched", 1, ov);
      clear();
      check("ov cleared", 0, ov);
      for (int c = 1; c < 8; c++) begin
         wr_reg(OFS_FAULT_SETUP_TWO, 32'(8'h80 | 8'h80 << 1 | c));
         clear();
         for (int n = 0; n <= rt[c]; n++) begin
            sup(44);
            sup(150);
            check("retry limit", n == rt[c], uv);
         end
         clear();
      end
      sup(150);
      step(200);
      check("bus volt bypass", 150, bus_volt);
      wr_reg(OFS_PIN_SETUP, 32'h0);
      sup(230);
      check("bus volt filter lag", 1, bus_volt !== 16'd230);
      step(200);
      check("bus volt settled", 230, bus_volt);
      @(posedge clk_i);
      stopped <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         k = 1'(rand32());
         wr_reg(OFS_PIN_SETUP, 32'((i >> 1) << 9));
         comm <= k;
         step(3);
         check("feedback stopped", exp_stop(i >> 1, k), fb);
      end
      for (int i = 0; i < 8; i++) begin
         wr_reg(OFS_PIN_SETUP, 32'((i >> 1) << 7));
         @(posedge clk_i);
         {ofault, stopped, comm, coast} <= {2'b00, i[0], 1'b1};
         {bemf, bthr} <= {16'd10, 16'd5};
         step(3);
         @(posedge clk_i);
         ofault <= 1'b1;
         comm <= !i[0];
         step(3);
         check("feedback fault", exp_fault(i >> 1, i[0], !i[0]), fb);
      end
      @(posedge clk_i);
      bemf <= 16'd2;
      comm <= 1'b1;
      step(3);
      check("feedback below bemf", 0, fb);
      for (int i = 0; i < 4; i++) begin
         rd_reg(OFS_PIN_SETUP, v);
         wr_reg(OFS_PIN_SETUP, (v & ~32'h40) | (32'(i[1]) << 6));
         ofault <= i[0];
         step(3);
         check("alarm", i[1] & i[0], alarm);
      end
      for (int i = 0; i < 32; i++) begin
         wr_reg(OFS_PIN_SETUP, 32'((i >> 1) << 2));
         brake <= i[0];
         step(5);
         k = exp_brake(i[2:1], i[0]);
         check("lowside brake", k & ~i[4], lsb);
         check("align brake", k & i[4], alb);
         if (k & i[4]) begin
            check("angle select", i[3], angle);
         end
      end
      for (int i = 0; i < 4; i++) begin
         wr_reg(OFS_PIN_SETUP, 32'(i));
         step(2);
         check("speed mode", i == 2 ? 0 : i, smode);
      end
      end_sim();
   end

endmodule : motor_hw_fault_config_bank_bench

`default_nettype wire
